// *** universal_bus_driver_18b.sv ***
// 18-channel universal bus driver: pass, latch or clocked capture, one mode shared by all channels
// one storage bit per channel, loaded while transparent or on a capture clock rise
// assumes all inputs synchronous to clock; captureClk is a sampled input, not a clock
// assumes the far side resolves a released line itself (pull-up or keeper)
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Contract
// - eighteen channels, input bit to output bit
// - output enable governs driven outputs
// - gate low: outputs follow inputs directly
// - gate high, steady clock: hold data
// - gate high: store on clock rise
// - enable high: all outputs high impedance
module universal_bus_driver_18b (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  // controls
  input  wire bus_driver_pkg::ctrl_t    ctrl,
  // data in
  input  wire bus_driver_pkg::chan_t    busIn,
  // driven outputs
  output var  bus_driver_pkg::tri_t     busOut,
  // observed mode
  output var  bus_driver_pkg::mode_t    mode
);

  ////////////////////////////////////////////////////////////////////////////////
  // state
  // storage: one bit per channel; clkPrev_q and the checker's heldRef_q are the block's other registers
  bus_driver_pkg::chan_t store_q;
  bus_driver_pkg::chan_t store_d;
  // capture clock level seen at the previous system clock edge
  logic                  clkPrev_q;
  logic                  clkPrev_d;
  // channel value before the output stage gates it onto the pins
  bus_driver_pkg::chan_t chanValue;
  // one-cycle pulse on a low-to-high step of the sampled capture clock
  logic                  clkRise;
  // checker helper: the value that every hold period must keep
  bus_driver_pkg::chan_t heldRef_q;
  bus_driver_pkg::chan_t heldRef_d;

  // rising edge of the sampled capture clock; a level that sits still never fires
  function automatic logic rising(input logic prev, input logic now);
    return ~prev & now;
  endfunction

  // edge detect from the registered level and the live pin
  always_comb begin
    clkRise = rising(clkPrev_q, ctrl.captureClk);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next-state of the channel storage
  // storage keeps working with outputs disabled, so old data survives a float
  // gate low wins over the clock, so a rise seen while transparent stores nothing extra
  always_comb begin
    clkPrev_d = ctrl.captureClk;
    store_d   = store_q;
    mode      = bus_driver_pkg::MODE_HOLD;
    if (!ctrl.captureGate_n) begin
      store_d = busIn;
      mode    = bus_driver_pkg::MODE_PASS;
    end else if (clkRise) begin
      store_d = busIn;
      mode    = bus_driver_pkg::MODE_CAPTURE;
    end
  end

  // registers only; the clock level is tracked through reset, so a pin already high at release is no edge
  always_ff @(posedge clock) begin
    clkPrev_q <= clkPrev_d;
    if (!rst_n) begin
      store_q <= bus_driver_pkg::STORE_RESET;
    end else begin
      store_q <= store_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // channel value: transparent path bypasses storage so no clock is awaited
  always_comb begin
    chanValue = ctrl.captureGate_n ? store_q : busIn;
  end

  // the enable is applied after the storage, so floating the pins never touches data
  output_stage i_output_stage (
    .outEnable_n (ctrl.outEnable_n),
    .value       (chanValue),
    .pins        (busOut)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // checker helper: a reference that loads the input whenever the rules allow a load
  // worked out from gate and rise alone, so a slip in store_d during a long hold shows up
  always_comb begin
    heldRef_d = heldRef_q;
    if (!ctrl.captureGate_n || clkRise) begin
      heldRef_d = busIn;
    end
  end

  // registers only; cleared with the storage so both start from one value
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      heldRef_q <= bus_driver_pkg::STORE_RESET;
    end else begin
      heldRef_q <= heldRef_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks: sampled on the system clock, after the combinational pin paths have settled
  // they watch the pins, the mode output, the storage, the reference and the edge detector against the caller's inputs
  // one clock edge seen as a transparent, a capture or a hold cycle
  sequence gateLow_s;
    !ctrl.captureGate_n;
  endsequence

  sequence gateHighRise_s;
    ctrl.captureGate_n && clkRise;
  endsequence

  sequence gateHighSteady_s;
    ctrl.captureGate_n && !clkRise;
  endsequence

  // transparent path needs no clock edge
  pass_follows_a: assert property (@(posedge clock) disable iff (!rst_n)
    !ctrl.captureGate_n |-> busOut.drive == busIn)
    else $error("transparent path does not follow input");

  // a rise shows its data one cycle later
  edge_capture_a: assert property (@(posedge clock) disable iff (!rst_n)
    gateHighRise_s ##1 ctrl.captureGate_n |-> busOut.drive == $past(busIn))
    else $error("rising clock did not capture input");

  // storage sits still when the capture clock does
  steady_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    gateHighSteady_s ##1 ctrl.captureGate_n |-> $stable(store_q))
    else $error("stored data changed without clock rise");

  // released whatever the other inputs do
  float_all_a: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl.outEnable_n |-> busOut.driveEn == '0)
    else $error("outputs driven while disabled");

  // enabled means every line is driven
  drive_all_a: assert property (@(posedge clock) disable iff (!rst_n)
    !ctrl.outEnable_n |-> &busOut.driveEn)
    else $error("outputs not driven while enabled");

  // a release follows the enable in the same cycle
  enable_governs_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(ctrl.outEnable_n) |-> busOut.driveEn == '0 && $past(&busOut.driveEn))
    else $error("enable change not reflected on outputs");

  // with the gate high the pins show the storage, bit for bit
  width_kept_a: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl.captureGate_n |-> busOut.drive == store_q)
    else $error("channel output differs from its storage");

  // two quiet cycles in a row leave the pins alone
  hold_data_a: assert property (@(posedge clock) disable iff (!rst_n)
    gateHighSteady_s ##1 gateHighSteady_s |-> $stable(busOut.drive))
    else $error("held output moved");

  // reported mode while transparent
  pass_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
    gateLow_s |-> mode == bus_driver_pkg::MODE_PASS)
    else $error("mode not pass while gate low");

  // reported mode on a capture rise
  capture_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
    gateHighRise_s |-> mode == bus_driver_pkg::MODE_CAPTURE)
    else $error("mode not capture on clock rise");

  // reported mode while holding
  hold_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
    gateHighSteady_s |-> mode == bus_driver_pkg::MODE_HOLD)
    else $error("mode not hold without clock rise");

  // closing the gate keeps the last transparent value
  pass_loads_store_a: assert property (@(posedge clock) disable iff (!rst_n)
    gateLow_s ##1 ctrl.captureGate_n |-> busOut.drive == $past(busIn))
    else $error("gate rise lost the transparent value");

  // a capture survives a following quiet cycle
  capture_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    gateHighRise_s ##1 gateHighSteady_s ##1 ctrl.captureGate_n |-> busOut.drive == $past(busIn, 2))
    else $error("captured value lost in the next hold");

  // however long a hold lasts, the pins keep the reference
  long_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl.captureGate_n |-> busOut.drive == heldRef_q)
    else $error("stored value drifted during hold");

  // the edge detector fires on a low-to-high step only
  rise_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
    clkRise |-> ctrl.captureClk && !$past(ctrl.captureClk))
    else $error("capture edge without a low-to-high step");

  // storage keeps loading while the pins float
  float_keeps_store_a: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl.outEnable_n && !ctrl.captureGate_n ##1 ctrl.captureGate_n |-> busOut.drive == $past(busIn))
    else $error("storage missed a load while released");

  // dropping the enable drives every line at once
  enable_drive_a: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(ctrl.outEnable_n) |-> &busOut.driveEn && ($past(busOut.driveEn) == '0))
    else $error("enable drop did not drive all lines");

  // and puts the current channel data on them
  reenable_data_a: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(ctrl.outEnable_n) |-> busOut.drive == (ctrl.captureGate_n ? heldRef_q : busIn))
    else $error("enable drop showed wrong data");

endmodule
`default_nettype wire

// *** bus_driver_pkg.sv ***
// package for the 18-channel universal bus driver
// assumes a single 10 MHz clock domain and no register bus
`default_nettype none
package bus_driver_pkg;

  // channel count
  localparam int unsigned CHANNELS = 18;

  // clock period in nanoseconds
  localparam int unsigned CLOCK_PERIOD_NS = 100;

  // reset value of the channel storage
  localparam logic [CHANNELS-1:0] STORE_RESET = 18'h00000;

  // capture modes derived from gate and clock
  typedef enum logic [1:0] {
    MODE_PASS,
    MODE_CAPTURE,
    MODE_HOLD
  } mode_t;

  // one group of channel bits
  typedef logic [CHANNELS-1:0] chan_t;

  // controls that travel together
  typedef struct packed {
    logic outEnable_n;
    logic captureGate_n;
    logic captureClk;
  } ctrl_t;

  // three-state output carrier
  typedef struct packed {
    chan_t drive;
    chan_t driveEn;
  } tri_t;

endpackage
`default_nettype wire

// *** output_stage.sv ***
// three-state output stage for the bus driver
// assumes the caller supplies the channel data, stored or passed straight through, and the active-low enable
`timescale 1ns/100ps
`default_nettype none
module output_stage (
  // control
  input  wire logic                     outEnable_n,
  // data
  input  wire bus_driver_pkg::chan_t    value,
  // pins
  output var  bus_driver_pkg::tri_t     pins
);

  // enable fans out to every channel; data always present, enable gates the wire
  always_comb begin
    pins.drive   = value;
    pins.driveEn = {bus_driver_pkg::CHANNELS{~outEnable_n}};
  end

endmodule
`default_nettype wire

// *** bus_load.sv ***
// downstream bus load model for the bus driver outputs
// assumes a pull-up on every line, so a released line reads high
`timescale 1ns/100ps
`default_nettype none
module bus_load (
  // pins from the driver
  input  wire bus_driver_pkg::tri_t  pins,
  // resolved line levels
  output var  bus_driver_pkg::chan_t level
);
  // a released line floats up, never keeping the last driven value
  always_comb level = (pins.drive & pins.driveEn) | ~pins.driveEn;
endmodule
`default_nettype wire

// *** test_universal_bus_driver_18b.sv ***
// self-checking bench for the 18-channel universal bus driver
// assumes one 10 MHz clock and combinational pin outputs
`timescale 1ns/100ps
`default_nettype none
module test_universal_bus_driver_18b;
  logic                  clock = 1'b0;
  logic                  rst_n = 1'b0;
  bus_driver_pkg::ctrl_t ctrl  = '0;
  bus_driver_pkg::chan_t busIn = 18'h00000;
  bus_driver_pkg::tri_t  busOut;
  bus_driver_pkg::mode_t mode;
  bus_driver_pkg::chan_t level;
  int                    bad_count = 0;
  int                    n_checks  = 0;

  universal_bus_driver_18b i_universal_bus_driver_18b (.clock(clock), .rst_n(rst_n), .ctrl(ctrl),
    .busIn(busIn), .busOut(busOut), .mode(mode));
  bus_load i_bus_load (.pins(busOut), .level(level));

  // half a period per toggle, period taken from the package
  always #(bus_driver_pkg::CLOCK_PERIOD_NS / 2) clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  // inputs change 1 ns after the rising edge, checks 5 ns later
  task step;
    @(posedge clock);
    #1;
  endtask

  task chk(input logic [17:0] seen, input logic [17:0] want);
    n_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task wrap_up;
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // gate low: pins follow input within the cycle, all enabled
  task pass_mode;
    busIn = 18'h2a5c3;
    #5;
    chk(level, 18'h2a5c3);
    chk(busOut.driveEn, 18'h3ffff);
    chk(18'(mode), 18'(bus_driver_pkg::MODE_PASS));
  endtask

  // gate high with a steady capture clock keeps the old value
  task hold_mode;
    step;
    ctrl.captureGate_n = 1'b1;
    step;
    busIn = 18'h15a3c;
    #5;
    chk(level, 18'h2a5c3);
    chk(18'(mode), 18'(bus_driver_pkg::MODE_HOLD));
  endtask

  // a rise stores once; a steady high afterwards holds
  task capture_mode;
    step;
    ctrl.captureClk = 1'b1;
    #5;
    chk(18'(mode), 18'(bus_driver_pkg::MODE_CAPTURE));
    step;
    busIn = 18'h3ffff;
    #5;
    chk(level, 18'h15a3c);
    step;
    #5;
    chk(level, 18'h15a3c);
  endtask

  // disabled outputs release every line whatever the data; storage still loads meanwhile
  task release_mode;
    step;
    ctrl.outEnable_n = 1'b1;
    busIn = 18'h00000;
    ctrl.captureGate_n = 1'b0;
    #5;
    chk(busOut.driveEn, 18'h00000);
    chk(level, 18'h3ffff);
    step;
    ctrl.outEnable_n = 1'b0;
    ctrl.captureGate_n = 1'b1;
    busIn = 18'h3ffff;
    #5;
    chk(level, 18'h00000);
    step;
    #5;
    chk(level, 18'h00000);
  endtask

  initial begin
    repeat (12) step;
    rst_n = 1'b1;
    pass_mode;
    hold_mode;
    capture_mode;
    release_mode;
    wrap_up;
  end
endmodule
`default_nettype wire
